// File: bench/cexc_tape_model.sv
// -----------------------------------------------------------------
// tape unit stand-in: clear leader after rewind, read track link
// -----------------------------------------------------------------
// assumes the exerciser drives rewind, motion and read commands
`timescale 1ns/1ps
module cexc_tape_model #(
    parameter int WIND_NS = 605,  // rewind time, kept off the clock edge
    parameter int LINK_NS = 160   // read clock period
) (
    input  wire logic rewind_i,    // rewind command
    input  wire logic moving_i,    // either drive direction
    input  wire logic reading_i,   // read command
    output logic      at_leader_o, // clear leader seen
    output logic      read_data_o, // data track bit
    output logic      read_clock_o // clock track bit
);
    // tape starts somewhere past leader
    initial begin
        at_leader_o = 1'b0;
        read_data_o = 1'b0;
        read_clock_o = 1'b0;
    end
    // rewind ends at clear leader after the wind time
    always @(posedge rewind_i) begin
        #(WIND_NS) at_leader_o = 1'b1;
    end
    // motion pulls the tape off leader
    always @(posedge moving_i) at_leader_o = 1'b0;
    // clock only within read frames, data line keeps changing
    always begin
        #(LINK_NS / 2);
        read_clock_o = (reading_i & moving_i) ? ~read_clock_o : 1'b0;
        read_data_o = ~read_data_o;
    end
endmodule // cexc_tape_model

// File: bench/tb.sv
// -----------------------------------------------------------------
// self-checking bench for the exerciser control block
// -----------------------------------------------------------------
// assumes short run, stop and cell counts set at the instance
`timescale 1ns/1ps
module tb;
    import cexc_pkg::*;
    localparam int RUN = 20, STOP = 20, CELL = 8;
    typedef struct {string name; int kind; logic [31:0] exp;} cexc_note_t;
    logic clk = 1'b0, resetn = 1'b0, run = 0, spd = 0, clip = 0, rwq = 0;
    logic mode = 0, wsel = 0, cas = 1, inpos = 0, tab = 0, clr = 0, en = 0;
    cexc_dir_t dir = CEXC_DIR_OFF;  // drive switch
    cexc_pat_t pat = CEXC_PAT_ZERO; // pattern switch
    logic lead, rdat, rclk, moving, spd_o, clip_o, rew_o, rev_o, fwd_o, rd_o, wr_o;
    logic wd_o, wc_o, rdy_l, lead_l, pos_l, spd_l, clip_l, rew_l, rev_l, fwd_l;
    logic rdl_l, rcl_l, tab_l, ws_l, wdl_l, wcl_l;
    logic [16:0] vec;             // static outputs
    logic [9:0]  mon, prv;        // counted outputs
    int          cnt [10];        // window counters
    int          mismatches = 0, num_checks = 0;
    bit   [31:0] seed = 1302, r;
    cexc_note_t  notes[$];        // expected results
    event        sample;
    localparam logic [9:0] EDGE = 10'h3C2; // counted on rises
    assign moving = fwd_o | rev_o;
    assign vec = {spd_o, clip_o, rew_o, rev_o, fwd_o, rd_o, wr_o, lead_l, pos_l,
                  spd_l, clip_l, rew_l, rev_l, fwd_l, tab_l, ws_l, rdy_l};
    assign mon = {rdat, rdl_l, rclk, rcl_l, wcl_l, wdl_l, fwd_l, wd_o, wc_o, fwd_o};
    always #5 clk = ~clk;
    cexc_top #(.RUN_CYC(RUN), .STOP_CYC(STOP), .CELL_CYC(CELL)) cexc_top_i (
        .ref_clk_i(clk), .resetn_i(resetn), .run_sw_i(run), .speed_select_i(spd),
        .read_clip_high_select_i(clip), .rewind_request_i(rwq), .drive_sel_i(dir),
        .motion_mode_select_i(mode), .write_sel_i(wsel), .write_pattern_select_i(pat),
        .cassette_in_i(cas), .at_leader_i(lead), .in_position_i(inpos),
        .write_tab_ok_i(tab), .read_data_i(rdat), .read_clock_i(rclk),
        .speed_high_o(spd_o), .read_clip_high_o(clip_o), .rewind_o(rew_o),
        .reverse_drive_o(rev_o), .forward_drive_o(fwd_o), .read_cmd_o(rd_o),
        .write_cmd_o(wr_o), .write_data_o(wd_o), .write_clock_o(wc_o),
        .tape_ready_lamp_o(rdy_l), .leader_lamp_o(lead_l), .tape_in_position_lamp_o(pos_l),
        .speed_lamp_o(spd_l), .clip_lamp_o(clip_l), .rewind_lamp_o(rew_l),
        .reverse_lamp_o(rev_l), .forward_lamp_o(fwd_l), .read_data_lamp_o(rdl_l),
        .read_clock_lamp_o(rcl_l), .write_permit_lamp_o(tab_l),
        .write_select_lamp_o(ws_l), .write_data_lamp_o(wdl_l), .write_clock_lamp_o(wcl_l));
    cexc_tape_model cexc_tape_model_i (.rewind_i(rew_o), .moving_i(moving),
        .reading_i(rd_o), .at_leader_o(lead), .read_data_o(rdat), .read_clock_o(rclk));
    // window counters: levels or rises of the watched outputs
    always @(posedge clk) begin
        prv <= mon;
        for (int k = 0; k < 10; k++) begin
            if (clr) cnt[k] <= 0;
            else if (en) cnt[k] <= cnt[k] + int'(EDGE[k] ? (mon[k] & ~prv[k]) : mon[k]);
        end
    end
    function automatic bit [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected static outputs from the switch and status levels
    function automatic logic [16:0] exp_vec(logic rew, logic rdy);
        logic e;
        e = run & ~rew;
        return {e & spd, e & clip, rew, e & (dir == CEXC_DIR_REV), e & (dir == CEXC_DIR_FWD),
                e & ~wsel, e & wsel, lead, inpos, e & spd, e & clip, rew,
                e & (dir == CEXC_DIR_REV), e & (dir == CEXC_DIR_FWD), tab, e & wsel, rdy};
    endfunction
    task automatic settle(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic compare(string nm, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic note(string nm, int kind, logic [31:0] exp);
        notes.push_back('{nm, kind, exp});
        @(negedge clk);
        -> sample;
        $display("test %s done", nm);
    endtask
    task automatic check_vec(string nm, logic rew, logic rdy);
        settle(8);
        note(nm, 0, 32'(exp_vec(rew, rdy)));
    endtask
    task automatic window(int n);
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) begin
            clr <= 1'b0;
            en <= 1'b1;
        end
        settle(n);
        en <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // watcher: oldest note against what the outputs show
    always @(sample) begin : watch
        cexc_note_t nt;
        logic [31:0] got;
        nt = notes.pop_front();
        if (nt.kind == 0) got = 32'(vec);
        else if (nt.kind == 9) got = 32'(cnt[7] > 4 && cnt[6] - cnt[7] <= 1 && cnt[7] - cnt[6] <= 1);
        // read data lamp rises against the data track rises
        else if (nt.kind == 10)
            got = 32'(cnt[9] > 4 && cnt[8] - cnt[9] <= 1 && cnt[9] - cnt[8] <= 1);
        else got = 32'(cnt[nt.kind - 1]);
        compare(nt.name, nt.exp, got);
    end
    // watchdog cuts a hang short
    initial begin
        #100us;
        mismatches++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        settle(8);
        resetn <= 1'b1;
        check_vec("ready before rewind", 0, 0);
        @(posedge clk) run <= 1'b1;
        @(posedge clk) spd <= 1'b1;
        check_vec("run idle", 0, 0);
        @(posedge clk) rwq <= 1'b1;
        settle(4);
        rwq <= 1'b0;
        check_vec("rewinding", 1, 0);
        settle(70);
        check_vec("rewound", 0, 1);
        for (int i = 0; i < 12; i++) begin
            r = xs();
            @(posedge clk) begin
                run <= r[0];
                spd <= r[1];
                clip <= r[2];
                inpos <= r[3];
                tab <= r[4];
                wsel <= r[4] & r[5];
                dir <= cexc_dir_t'(r[7:6] % 3);
            end
            check_vec("switch mix", 0, 1);
        end
        @(posedge clk) begin
            run <= 1'b1;
            wsel <= 1'b1;
            tab <= 1'b1;
            dir <= CEXC_DIR_OFF;
        end
        for (int p = 0; p < 3; p++) begin
            @(posedge clk) pat <= cexc_pat_t'(p);
            settle(2 * CELL + 4);
            window(8 * CELL);
            note("data ones", 3, 32'(p * 4 * CELL));
            note("data lamp ones", 5, 32'(p * 4 * CELL));
            note("clock pulses", 2, 8);
            note("clock lamp high", 6, 32'(4 * CELL));
        end
        @(posedge clk) begin
            mode <= 1'b1;
            dir <= CEXC_DIR_FWD;
        end
        settle(60);
        window(2 * (RUN + STOP));
        note("start stop drive", 1, 32'(2 * RUN));
        note("start stop lamp", 4, 32'(2 * (RUN + STOP)));
        note("pattern through stops", 2, 32'(2 * (RUN + STOP) / CELL));
        @(posedge clk) begin
            mode <= 1'b0;
            wsel <= 1'b0;
        end
        settle(20);
        window(320);
        note("read clock lamp", 9, 1);
        note("read data lamp", 10, 1);
        @(posedge clk) cas <= 1'b0;
        check_vec("cassette out", 0, 0);
        tally_and_finish();
    end
endmodule // tb

// File: design/cexc_pattern_gen.sv
// free running write pattern generator for the exerciser
// assumes enable and pattern come from logic on the same clock
`timescale 1ns/1ps
`include "cexc_defines.svh"
module cexc_pattern_gen #(
    parameter int CELL_CYC = `CEXC_CELL_CYC
) (
    input  wire logic   ref_clk_i,
    input  wire logic   resetn_i,
    cexc_pat_if.gen     pat
);
    import cexc_pkg::*;
    initial begin
        if (CELL_CYC < 4) $error("cell too short");
    end
    logic [31:0] cell_q;  // cycles into the bit cell
    logic        alt_q;   // alternating data bit
    logic        data_q;  // data bit registered
    logic        pls_q;   // clock pulse registered
    wire         cell_end = (cell_q == 32'(CELL_CYC - 1));
    wire         pls_on   = pat.enable && (cell_q < 32'(CELL_CYC / 2));
    wire         data_nxt = (pat.pattern == CEXC_PAT_ONE) ||
                            ((pat.pattern == CEXC_PAT_ALT) && alt_q);
    // ----------------------------------------------
    // cell counter never pauses, enable gates only the data bit and clock pulse
    // ----------------------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cell_q <= 32'h0;
            alt_q  <= 1'b0;
            data_q <= 1'b0;
            pls_q  <= 1'b0;
        end else begin
            cell_q <= cell_end ? 32'h0 : cell_q + 32'h1;
            if (cell_end) alt_q <= ~alt_q;
            data_q <= pat.enable && data_nxt;
            pls_q  <= pls_on;
        end
    end
    assign pat.data    = data_q;
    assign pat.clk_pls = pls_q;
endmodule // cexc_pattern_gen

// File: design/cexc_top.sv
// control and lamp logic of the cassette tape exerciser
// assumes panel switches and tape unit status arrive unsynchronised
`timescale 1ns/1ps
`include "cexc_defines.svh"
// Behaviour
// - run switch off disables all functions
// - speed switch selects high or normal speed
// - clipping switch selects high or normal threshold
// - rewind switch starts rewind, leader ends it
// - rewind overrides other functions and lamps except the ready, leader, position and write permit lamps
// - drive switch: reverse, none, forward
// - mode switch: start/stop or continuous
// - select switch: read up, write down
// - pattern switch: zeros, alternating, ones
// - run interval at least fifty milliseconds
// - stop interval at least fifty milliseconds
// - ready lamp after insert and full rewind
// - leader lamp follows clear leader status
// - position lamp between start and end holes
// - speed and clipping lamps follow selections
// - rewind lamp follows its command, reverse and forward lamps follow drive switch
// - read lamps follow read ones
// - write permit lamp follows write tab
// - write select lamp follows select switch
// - write lamps follow written ones
// - writing continues during start/stop pauses
module cexc_top #(
    parameter int RUN_CYC  = `CEXC_MIN_RUN_CYC,
    parameter int STOP_CYC = `CEXC_MIN_STOP_CYC,
    parameter int CELL_CYC = `CEXC_CELL_CYC
) (
    input  wire logic              ref_clk_i,
    input  wire logic              resetn_i,
    input  wire logic              run_sw_i,           // master run switch
    input  wire logic              speed_select_i,     // high speed switch
    input  wire logic              read_clip_high_select_i,
    input  wire logic              rewind_request_i,   // momentary switch
    input  wire cexc_pkg::cexc_dir_t drive_sel_i,      // drive switch
    input  wire logic              motion_mode_select_i, // 1 start/stop
    input  wire logic              write_sel_i,        // 1 write, 0 read
    input  wire cexc_pkg::cexc_pat_t write_pattern_select_i,
    input  wire logic              cassette_in_i,      // cassette loaded
    input  wire logic              at_leader_i,        // clear leader seen
    input  wire logic              in_position_i,      // between holes
    input  wire logic              write_tab_ok_i,     // write allowed
    input  wire logic              read_data_i,        // read data track
    input  wire logic              read_clock_i,       // read clock track
    output logic                   speed_high_o,
    output logic                   read_clip_high_o,
    output logic                   rewind_o,
    output logic                   reverse_drive_o,
    output logic                   forward_drive_o,
    output logic                   read_cmd_o,
    output logic                   write_cmd_o,
    output logic                   write_data_o,
    output logic                   write_clock_o,
    output logic                   tape_ready_lamp_o,
    output logic                   leader_lamp_o,
    output logic                   tape_in_position_lamp_o,
    output logic                   speed_lamp_o,
    output logic                   clip_lamp_o,
    output logic                   rewind_lamp_o,
    output logic                   reverse_lamp_o,
    output logic                   forward_lamp_o,
    output logic                   read_data_lamp_o,
    output logic                   read_clock_lamp_o,
    output logic                   write_permit_lamp_o,
    output logic                   write_select_lamp_o,
    output logic                   write_data_lamp_o,
    output logic                   write_clock_lamp_o
);
    import cexc_pkg::*;
    localparam int NSYNC = 16;
    initial begin
        if (RUN_CYC < 1 || STOP_CYC < 1) $error("interval below one cycle");
    end
    // ----------------------------------------------
    // input synchronisers
    // ----------------------------------------------
    logic [NSYNC-1:0] raw;     // asynchronous inputs gathered
    logic [NSYNC-1:0] s1_q;    // first stage, read only by s2
    logic [NSYNC-1:0] s2_q;    // synchronised copy
    assign raw = {run_sw_i, speed_select_i, read_clip_high_select_i, rewind_request_i,
                  drive_sel_i, motion_mode_select_i, write_sel_i,
                  write_pattern_select_i, cassette_in_i, at_leader_i,
                  in_position_i, write_tab_ok_i, read_data_i, read_clock_i};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            // two flops per bit
            always_ff @(posedge ref_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= raw[gi];
                    s2_q[gi] <= s1_q[gi];
                end
            end
        end
    endgenerate
    // named views of the synchronised inputs
    wire       run      = s2_q[15];
    wire       spd      = s2_q[14];
    wire       clip     = s2_q[13];
    wire       rwd_sw   = s2_q[12];
    wire [1:0] dir_raw  = s2_q[11:10];
    wire       ss_mode  = s2_q[9];
    wire       wr_sel   = s2_q[8];
    wire [1:0] pat_raw  = s2_q[7:6];
    wire       cass_in  = s2_q[5];
    wire       leader   = s2_q[4];
    wire       in_pos   = s2_q[3];
    wire       tab_ok   = s2_q[2];
    wire       rd_data  = s2_q[1];
    wire       rd_clk   = s2_q[0];
    // ----------------------------------------------
    // rewind and ready state
    // ----------------------------------------------
    logic        rwd_q;      // rewind in effect
    logic        ready_q;    // rewound since insertion
    cexc_phase_t phase_q;    // start/stop phase
    logic [31:0] ph_cnt_q;   // cycles into phase
    wire rwd_start = run && rwd_sw && !leader;
    wire rwd_d     = run && (rwd_start || (rwd_q && !leader));
    wire ready_d   = cass_in && (ready_q || (rwd_q && leader));
    wire ph_end    = (phase_q == CEXC_PH_RUN) ?
                     (ph_cnt_q >= 32'(RUN_CYC - 1)) :
                     (ph_cnt_q >= 32'(STOP_CYC - 1));
    // ----------------------------------------------
    // command decode
    // ----------------------------------------------
    wire active   = run && !rwd_q;
    wire ss_go    = !ss_mode || (phase_q == CEXC_PH_RUN);
    wire rev_d    = active && (dir_raw == 2'(CEXC_DIR_REV)) && ss_go;
    wire fwd_d    = active && (dir_raw == 2'(CEXC_DIR_FWD)) && ss_go;
    wire rev_lamp = active && (dir_raw == 2'(CEXC_DIR_REV));
    wire fwd_lamp = active && (dir_raw == 2'(CEXC_DIR_FWD));
    wire wr_on    = active && wr_sel;
    wire rd_on    = active && !wr_sel;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rwd_q    <= 1'b0;
            ready_q  <= 1'b0;
            phase_q  <= CEXC_PH_RUN;
            ph_cnt_q <= 32'h0;
        end else begin
            rwd_q    <= rwd_d;
            ready_q  <= ready_d;
            if (!active || !ss_mode) begin
                phase_q  <= CEXC_PH_RUN;
                ph_cnt_q <= 32'h0;
            end else if (ph_end) begin
                phase_q  <= (phase_q == CEXC_PH_RUN) ? CEXC_PH_STOP : CEXC_PH_RUN;
                ph_cnt_q <= 32'h0;
            end else begin
                ph_cnt_q <= ph_cnt_q + 32'h1;
            end
        end
    end
    // ----------------------------------------------
    // pattern generator
    // ----------------------------------------------
    cexc_pat_if pat_bus ();
    assign pat_bus.enable  = wr_on;
    assign pat_bus.pattern = cexc_pat_t'(pat_raw);
    cexc_pattern_gen #(.CELL_CYC(CELL_CYC)) u_gen (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .pat       (pat_bus.gen)
    );
    // ----------------------------------------------
    // output registers
    // ----------------------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            speed_high_o            <= 1'b0;
            read_clip_high_o        <= 1'b0;
            rewind_o                <= 1'b0;
            reverse_drive_o         <= 1'b0;
            forward_drive_o         <= 1'b0;
            read_cmd_o              <= 1'b0;
            write_cmd_o             <= 1'b0;
            write_data_o            <= 1'b0;
            write_clock_o           <= 1'b0;
            tape_ready_lamp_o       <= 1'b0;
            leader_lamp_o           <= 1'b0;
            tape_in_position_lamp_o <= 1'b0;
            speed_lamp_o            <= 1'b0;
            clip_lamp_o             <= 1'b0;
            rewind_lamp_o           <= 1'b0;
            reverse_lamp_o          <= 1'b0;
            forward_lamp_o          <= 1'b0;
            read_data_lamp_o        <= 1'b0;
            read_clock_lamp_o       <= 1'b0;
            write_permit_lamp_o     <= 1'b0;
            write_select_lamp_o     <= 1'b0;
            write_data_lamp_o       <= 1'b0;
            write_clock_lamp_o      <= 1'b0;
        end else begin
            speed_high_o            <= active && spd;
            read_clip_high_o        <= active && clip;
            rewind_o                <= rwd_q;
            reverse_drive_o         <= rev_d;
            forward_drive_o         <= fwd_d;
            read_cmd_o              <= rd_on;
            write_cmd_o             <= wr_on;
            write_data_o            <= pat_bus.data;
            write_clock_o           <= pat_bus.clk_pls;
            tape_ready_lamp_o       <= ready_q;
            leader_lamp_o           <= leader;
            tape_in_position_lamp_o <= in_pos;
            speed_lamp_o            <= active && spd;
            clip_lamp_o             <= active && clip;
            rewind_lamp_o           <= rwd_q;
            reverse_lamp_o          <= rev_lamp;
            forward_lamp_o          <= fwd_lamp;
            read_data_lamp_o        <= rd_on && rd_data;
            read_clock_lamp_o       <= rd_on && rd_clk;
            write_permit_lamp_o     <= tab_ok;
            write_select_lamp_o     <= active && wr_sel;
            write_data_lamp_o       <= pat_bus.data;
            write_clock_lamp_o      <= pat_bus.clk_pls;
        end
    end
    // ----------------------------------------------
    // assertions
    // ----------------------------------------------
    property p_run_off_idle;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !run |=> !(reverse_drive_o || forward_drive_o || write_cmd_o || read_cmd_o);
    endproperty
    a_run_off_idle: assert property (p_run_off_idle) else $error("command with run off");
    property p_rwd_prio;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        rwd_q |=> !(reverse_lamp_o || forward_lamp_o || write_cmd_o || speed_lamp_o);
    endproperty
    a_rwd_prio: assert property (p_rwd_prio) else $error("rewind not overriding");
    property p_rwd_end;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        rwd_q && leader |=> ##1 !rewind_o;
    endproperty
    a_rwd_end: assert property (p_rwd_end) else $error("rewind past leader");
    property p_ready;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(tape_ready_lamp_o) |-> $past(cass_in, 2);
    endproperty
    a_ready: assert property (p_ready) else $error("ready without cassette");
    property p_run_len;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(phase_q == CEXC_PH_STOP) |-> $past(ph_cnt_q) == 32'(RUN_CYC - 1);
    endproperty
    a_run_len: assert property (p_run_len) else $error("run interval wrong");
    property p_stop_len;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        $fell(phase_q == CEXC_PH_STOP) && $past(active) && $past(ss_mode)
        |-> $past(ph_cnt_q) == 32'(STOP_CYC - 1);
    endproperty
    a_stop_len: assert property (p_stop_len) else $error("stop interval wrong");
    sequence s_wr_hold;
        wr_on [*2];
    endsequence
    // writing must not be gated by the stop phase of start/stop motion
    property p_wr_cont;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        s_wr_hold ##0 (phase_q == CEXC_PH_STOP) |=> write_cmd_o;
    endproperty
    a_wr_cont: assert property (p_wr_cont) else $error("write paused");
    property p_leader;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        1'b1 |=> leader_lamp_o == $past(leader);
    endproperty
    a_leader: assert property (p_leader) else $error("leader lamp mismatch");
endmodule // cexc_top

// File: shared/cexc_defines.svh
// timing counts and widths for the cassette exerciser control block
// assumes a 100 MHz system clock
`ifndef CEXC_DEFINES_SVH
`define CEXC_DEFINES_SVH
`define CEXC_CLK_MHZ        100
`define CEXC_MIN_RUN_MS     50
`define CEXC_MIN_STOP_MS    50
`define CEXC_MIN_RUN_CYC    (`CEXC_MIN_RUN_MS * 1000 * `CEXC_CLK_MHZ)
`define CEXC_MIN_STOP_CYC   (`CEXC_MIN_STOP_MS * 1000 * `CEXC_CLK_MHZ)
`define CEXC_CELL_CYC       1000
`define CEXC_CTR_W          32
`endif

// File: shared/cexc_pat_if.sv
// carrier between the exerciser top and its pattern generator
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface cexc_pat_if;
    import cexc_pkg::*;
    logic      enable;  // gates the data bit and clock pulse
    cexc_pat_t pattern; // chosen data pattern
    logic      data;    // data track bit
    logic      clk_pls; // clock track pulse
    modport ctrl (output enable, output pattern, input data, input clk_pls);
    modport gen  (input enable, input pattern, output data, output clk_pls);
endinterface

// File: shared/cexc_pkg.sv
// types shared by the cassette exerciser control block
// assumes nothing beyond the defines header
package cexc_pkg;
    // drive switch position
    typedef enum logic [1:0] {CEXC_DIR_OFF, CEXC_DIR_REV, CEXC_DIR_FWD} cexc_dir_t;
    // data track pattern switch position
    typedef enum logic [1:0] {CEXC_PAT_ZERO, CEXC_PAT_ALT, CEXC_PAT_ONE} cexc_pat_t;
    // start/stop phase
    typedef enum logic [0:0] {CEXC_PH_RUN, CEXC_PH_STOP} cexc_phase_t;
endpackage
